// >>> acsp_pkg.sv
// Shared constants for the converter serial port block.
// Assumes a single system clock; serial pins arrive asynchronously.
package acsp_pkg;
   localparam int          FRAME_BITS    = 16;
   localparam int          CTRL_BITS     = 8;
   localparam int          RESULT_BITS   = 12;
   localparam int          LEAD_ZEROS    = 4;
   localparam int          CNT_W         = 5;
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   localparam logic [1:0]  PM_CS_SHUTDN  = 2'h0;
   localparam logic [1:0]  PM_ALWAYS_ON  = 2'h1;
   localparam int          PM_LSB        = 0;
   localparam int          CH_BIT        = 3;
   localparam int          DUAL_BIT      = 4;
   localparam int          REF_OFF_BIT   = 5;
   localparam logic [4:0]  CNT_ZERO      = 5'h00;
   localparam logic [4:0]  CNT_ONE       = 5'h01;
   localparam logic [4:0]  CNT_CTRL_LAST = 5'h08;
   localparam logic [4:0]  CNT_FRAME_END = 5'h10;
   localparam logic [1:0]  BUF_CNT_NONE  = 2'h0;
   localparam logic [1:0]  BUF_CNT_ONE   = 2'h1;
   localparam logic [1:0]  BUF_CNT_FULL  = 2'h2;
endpackage : acsp_pkg

// >>> acsp_serial_port.sv
// Serial port of a two-input 12-bit sampling converter, device side.
// Assumes chip select, serial clock and input data are asynchronous pins,
// and the conversion core hands results through a valid/ready word port.
`timescale 1ns/1ns

// Notes on behaviour
// - A falling chip select starts a conversion and frames one serial transfer.
// - In the default power setting the device is powered down while chip select is high.
// - The input line is sampled into the control register on serial clock rising edges.
// - Each result bit after the first is driven onto the output line after a serial clock falling edge.
// - A frame carries four zero bits, then the 12-bit result with msb first.
// - The serial clock paces transfer and conversion; select falling gives the start, first bit, buffer pop, output enable and mode 00 power-up.
// - A transfer takes 16 serial clocks, with control bits in while result bits go out.
// - Only the first eight rising edges after chip select falls load the control register.
// - After reset the control register holds zero, giving single input and select-led power.
// - Mode 00 powers up on select falling and down on rising; mode 01 stays powered.
module acsp_serial_port #(
   parameter int DATA_W = acsp_pkg::RESULT_BITS
) (
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic              cs_n,
   input  wire logic              sclk,
   input  wire logic              sdin,
   input  wire logic [DATA_W-1:0] result_data,
   input  wire logic              result_valid,
   output logic                   result_ready,
   output logic                   sdout_o,
   output logic                   sdout_oe,
   output logic                   powered_up,
   output logic                   conv_start,
   output logic                   conv_tick,
   output logic                   dual_mode,
   output logic                   chan_sel,
   output logic                   ref_off
);
   import acsp_pkg::*;

   typedef enum logic [1:0] {
      ACSP_IDLE  = 2'b01,
      ACSP_FRAME = 2'b10
   } acsp_state_e;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers, two stages each; first stage read by nothing else
   logic [1:0] cs_sync_ff;
   logic [1:0] sclk_sync_ff;
   logic [1:0] din_sync_ff;
   logic       sclk_last_ff;
   logic       cs_last_ff;

   always_ff @(posedge clock) begin
      if (rst) begin
         // Idle pin levels, so no false edge follows reset
         cs_sync_ff   <= '1;
         sclk_sync_ff <= '0;
         din_sync_ff  <= '0;
         sclk_last_ff <= 1'b0;
         cs_last_ff   <= 1'b1;
      end else begin
         cs_sync_ff   <= {cs_sync_ff[0], cs_n};
         sclk_sync_ff <= {sclk_sync_ff[0], sclk};
         din_sync_ff  <= {din_sync_ff[0], sdin};
         sclk_last_ff <= sclk_sync_ff[1];
         cs_last_ff   <= cs_sync_ff[1];
      end
   end

   // Edge decode of the synchronised pins
   // Pin-to-use latency is three clocks, so each serial clock phase
   // must last at least three system clocks to be seen
   wire cs_low    = ~cs_sync_ff[1];
   wire cs_fall   = cs_last_ff & ~cs_sync_ff[1];
   wire sclk_rise = sclk_sync_ff[1] & ~sclk_last_ff;
   wire sclk_fall = ~sclk_sync_ff[1] & sclk_last_ff;

   ////////////////////////////////////////////////////////////////////////
   // Two-entry buffer between the conversion core and the shifter
   // Depth two covers one word in flight while the next one waits
   logic [DATA_W-1:0] buf_mem_ff [2];
   logic              buf_wr_ff;
   logic              buf_rd_ff;
   logic [1:0]        buf_cnt_ff;

   wire buf_full  = (buf_cnt_ff == BUF_CNT_FULL);
   wire buf_empty = (buf_cnt_ff == BUF_CNT_NONE);
   // Take a word only when ready was shown, so a core that holds valid
   // through a not-ready cycle never lands the same word twice
   wire buf_push  = result_valid & result_ready;
   wire buf_pop;
   wire [DATA_W-1:0] buf_head = buf_mem_ff[buf_rd_ff];

   // Occupancy tracking; a stalled shifter back-pressures the core
   always_ff @(posedge clock) begin
      if (rst) begin
         buf_wr_ff    <= 1'b0;
         buf_rd_ff    <= 1'b0;
         buf_cnt_ff   <= BUF_CNT_NONE;
         result_ready <= 1'b0;
      end else begin
         if (buf_push) begin
            buf_mem_ff[buf_wr_ff] <= result_data;
            buf_wr_ff             <= ~buf_wr_ff;
         end
         if (buf_pop)
            buf_rd_ff <= ~buf_rd_ff;
         buf_cnt_ff   <= buf_cnt_ff + {1'b0, buf_push} - {1'b0, buf_pop};
         // Ready looks one word ahead; it may rise a cycle late, never drop late
         result_ready <= ~(buf_full || (buf_cnt_ff == BUF_CNT_ONE && buf_push && !buf_pop));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame sequencer
   acsp_state_e           state_ff;
   acsp_state_e           nxt_state;
   logic [CNT_W-1:0]      rise_cnt_ff;
   logic [CNT_W-1:0]      fall_cnt_ff;
   logic [CTRL_BITS-1:0]  ctrl_ff;
   logic [CTRL_BITS-2:0]  ctrl_shift_ff;
   logic [FRAME_BITS-1:0] tx_shift_ff;

   // Saturating step shared by both edge counters; both stop at the frame length
   function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] cnt);
      cnt_step = (cnt == CNT_FRAME_END) ? cnt : cnt + CNT_ONE;
   endfunction : cnt_step

   // Frame word: leading zeros then result msb first; an empty buffer sends zeros
   wire [FRAME_BITS-1:0] frame_word =
      {{LEAD_ZEROS{1'b0}}, (buf_empty ? {DATA_W{1'b0}} : buf_head)};
   assign buf_pop = cs_fall & ~buf_empty;

   // Control takes only the first eight rises; the output runs all sixteen falls
   wire in_frame   = (state_ff == ACSP_FRAME);
   wire ctrl_take  = in_frame & sclk_rise & (rise_cnt_ff < CNT_CTRL_LAST);
   wire ctrl_done  = ctrl_take & (rise_cnt_ff == CNT_CTRL_LAST - CNT_ONE);
   wire tx_step    = in_frame & sclk_fall & (fall_cnt_ff != CNT_FRAME_END);
   wire [CTRL_BITS-1:0] ctrl_next = {ctrl_shift_ff, din_sync_ff[1]};
   wire [1:0] pm   = ctrl_ff[PM_LSB +: 2];
   // Unused codes fall back to select-led power; a safe low-power choice
   wire pwr_next   = (pm == PM_ALWAYS_ON) | cs_low;

   // A select fall enters the frame state and select level alone ends it; a cut frame simply
   // drops back to idle when select rises
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ACSP_IDLE:  if (cs_fall) nxt_state = ACSP_FRAME;
         ACSP_FRAME: if (!cs_low) nxt_state = ACSP_IDLE;
      endcase
   end

   // Frame state and one-cycle strobes towards the conversion core
   always_ff @(posedge clock) begin
      if (rst) begin
         state_ff   <= ACSP_IDLE;
         powered_up <= 1'b0;
         conv_start <= 1'b0;
         conv_tick  <= 1'b0;
         sdout_oe   <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         powered_up <= pwr_next;
         conv_start <= cs_fall;
         // Conversion paced by host falling edges only, at most 16 a frame
         conv_tick  <= tx_step;
         sdout_oe   <= cs_low;
      end
   end

   // Control capture on rising edges; a frame cut before the 8th
   // edge leaves the previous setting in force
   always_ff @(posedge clock) begin
      if (rst) begin
         rise_cnt_ff   <= CNT_ZERO;
         ctrl_shift_ff <= '0;
         ctrl_ff       <= CTRL_RESET;
      end else if (cs_fall) begin
         rise_cnt_ff   <= CNT_ZERO;
      end else if (in_frame) begin
         if (sclk_rise)
            rise_cnt_ff <= cnt_step(rise_cnt_ff);
         if (ctrl_take)
            ctrl_shift_ff <= ctrl_next[CTRL_BITS-2:0];
         if (ctrl_done)
            ctrl_ff <= ctrl_next;
      end
   end

   // Result shifter: the first bit stands from select falling and each later
   // bit follows a falling edge, so the host reads every bit on a rise
   always_ff @(posedge clock) begin
      if (rst) begin
         fall_cnt_ff <= CNT_ZERO;
         tx_shift_ff <= '0;
         sdout_o     <= 1'b0;
      end else if (cs_fall) begin
         fall_cnt_ff <= CNT_ZERO;
         sdout_o     <= frame_word[FRAME_BITS-1];
         tx_shift_ff <= {frame_word[FRAME_BITS-2:0], 1'b0};
      end else if (tx_step) begin
         sdout_o     <= tx_shift_ff[FRAME_BITS-1];
         tx_shift_ff <= {tx_shift_ff[FRAME_BITS-2:0], 1'b0};
         fall_cnt_ff <= cnt_step(fall_cnt_ff);
      end
   end

   // Decoded control fields; channel select only counts in dual mode,
   // so it is gated here rather than left to the core
   always_ff @(posedge clock) begin
      if (rst) begin
         dual_mode <= 1'b0;
         chan_sel  <= 1'b0;
         ref_off   <= 1'b0;
      end else begin
         dual_mode <= ctrl_ff[DUAL_BIT];
         chan_sel  <= ctrl_ff[CH_BIT] & ctrl_ff[DUAL_BIT];
         ref_off   <= ctrl_ff[REF_OFF_BIT];
      end
   end
endmodule : acsp_serial_port

// >>> acsp_port_chk_asserts.sv
// Pin-level assertions for the converter serial port.
// Assumes pins reach the logic through two-stage synchronisers.
`timescale 1ns/1ns
module acsp_port_chk (
   input wire logic clock,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdout_o,
   input wire logic sdout_oe,
   input wire logic powered_up,
   input wire logic conv_start,
   input wire logic conv_tick,
   input wire logic dual_mode,
   input wire logic chan_sel
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);
   // Windows allow for sync delay, not for a missing response
   start_pulse_a: assert property ($fell(cs_n) |-> ##[2:4] conv_start)
      else $error("start pulse missing");
   lead_zero_a: assert property (conv_start |-> ##1 (sdout_oe && !sdout_o))
      else $error("first bit not a driven zero");
   tick_gate_a: assert property (conv_tick |-> !sclk && !cs_n)
      else $error("tick outside a serial low phase");
   dout_hold_a: assert property ($rose(sclk) |-> $stable(sdout_o))
      else $error("output moved on a rising edge");
   oe_idle_a: assert property (cs_n [*6] |-> !sdout_oe)
      else $error("output driven while deselected");
   pwr_frame_a: assert property (!cs_n [*6] |-> powered_up)
      else $error("not powered inside a frame");
   ctrl_hold_a: assert property (cs_n |-> $stable({dual_mode, chan_sel}))
      else $error("control moved outside a frame");
   chan_gate_a: assert property (chan_sel |-> dual_mode)
      else $error("channel select without dual mode");
endmodule : acsp_port_chk

bind acsp_serial_port acsp_port_chk acsp_port_chk_inst (.clock, .rst, .cs_n, .sclk,
   .sdout_o, .sdout_oe, .powered_up, .conv_start, .conv_tick, .dual_mode, .chan_sel);

// >>> acsp_host_model.sv
// Host master: drives select, serial clock and input line.
// Assumes callers enter just after a system clock edge.
`timescale 1ns/1ns
module acsp_host_model (
   input  wire logic clock,
   output logic      cs_n,
   output logic      sclk,
   output logic      sdin,
   input  wire logic sdout_o,
   input  wire logic sdout_oe
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdin = 1'b0;
   end
   // Six clocks a phase keeps sclk well under the sync limit
   task automatic frame(input logic [15:0] din, output logic [15:0] rx);
      cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         sdin <= din[i];
         repeat (6) @(posedge clock);
         // A released line reads as its inverse, so a late enable shows up
         rx[i] = sdout_oe ? sdout_o : ~sdout_o;
         sclk <= 1'b1;
         repeat (6) @(posedge clock);
         sclk <= 1'b0;
      end
      repeat (6) @(posedge clock);
      cs_n <= 1'b1;
      sdin <= 1'b0;
      repeat (8) @(posedge clock);
   endtask : frame
endmodule : acsp_host_model

// >>> acsp_serial_port_tb.sv
// Self-checking bench for the converter serial port.
// Assumes the host model and the bound pin checker.
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
   $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module acsp_serial_port_tb;
   import acsp_pkg::*;
   logic        clock, rst, cs_n, sclk, sdin, result_valid, result_ready;
   logic        sdout_o, sdout_oe, powered_up, conv_start, conv_tick;
   logic        dual_mode, chan_sel, ref_off;
   logic [11:0] result_data;
   logic [15:0] rx;
   int          failures = 0;
   int          checked = 0;
   int          ticks = 0;
   int          starts = 0;
   acsp_serial_port acsp_serial_port_inst (.clock, .rst, .cs_n, .sclk, .sdin, .result_data,
      .result_valid, .result_ready, .sdout_o, .sdout_oe, .powered_up, .conv_start,
      .conv_tick, .dual_mode, .chan_sel, .ref_off);
   acsp_host_model acsp_host_model_inst (.clock, .cs_n, .sclk, .sdin, .sdout_o, .sdout_oe);
   // Strobe tallies, read as differences around each frame
   always @(posedge clock) begin
      if (conv_tick === 1'b1)
         ticks++;
      if (conv_start === 1'b1)
         starts++;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results
   // One host frame, judged on its strobes; callers check its data in rx
   task automatic run_frame(input logic [15:0] din);
      int t0;
      int s0;
      t0 = ticks;
      s0 = starts;
      acsp_host_model_inst.frame(din, rx);
      `CHK(ticks - t0, 16)
      `CHK(starts - s0, 1)
   endtask : run_frame
   // Holds the word until the buffer takes it, bounded; a gap edge follows
   task automatic push(input logic [11:0] w);
      result_data <= w;
      result_valid <= 1'b1;
      for (int i = 0; i < 20; i++) begin
         @(posedge clock);
         if (result_ready === 1'b1) break;
      end
      `CHK(result_ready, 1'b1)
      result_valid <= 1'b0;
      @(posedge clock);
   endtask : push
   task automatic t_fill;
      push(12'hA5C);
      push(12'h3F1);
      repeat (3) @(posedge clock);
      `CHK(result_ready, 1'b0)
      $display("t_fill done");
   endtask : t_fill
   // Later input bits all ones must not reach control
   task automatic t_dual;
      run_frame(16'h11FF);
      `CHK(rx, 16'h0A5C)
      `CHK({dual_mode, chan_sel, ref_off, powered_up}, 4'b1001)
      $display("t_dual done");
   endtask : t_dual
   task automatic t_chan;
      run_frame(16'h3800);
      `CHK(rx, 16'h03F1)
      `CHK({dual_mode, chan_sel, ref_off, powered_up}, 4'b1110)
      $display("t_chan done");
   endtask : t_chan
   // Empty buffer and a grounded input line
   task automatic t_readonly;
      run_frame(16'h0000);
      `CHK(rx, 16'h0000)
      `CHK({dual_mode, chan_sel, ref_off, powered_up}, 4'b0000)
      $display("t_readonly done");
   endtask : t_readonly
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   initial begin
      repeat (5000) @(posedge clock);
      failures++;
      results();
   end
   initial begin
      rst = 1'b1;
      result_valid = 1'b0;
      result_data = 12'h000;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      `CHK({powered_up, sdout_oe, dual_mode, ref_off, result_ready}, 5'h01)
      t_fill();
      t_dual();
      t_chan();
      t_readonly();
      results();
   end
endmodule : acsp_serial_port_tb
